// *** zone_lock_and_ephemeral_key.sv ***
// Zone lock gating and ephemeral key register with its metadata.
// Assumes an APB master in the ref_clk domain; inputs are synchronous.
// Summary of operation
// - Config writes only while config lock byte is 55h; reads always.
// - Fixed config bytes 0 to 12 are never writable.
// - Data and OTP zones unlocked exactly when data lock byte is 55h.
// - No data or OTP access before config zone is locked.
// - Config locked, data unlocked: writes allowed, reads refused.
// - Both locked: slot settings decide read and write permission.
// - Sleep or power loss wipes key and scratch state.
// - Key value never returned through an external read.
// - Keep 256-bit key plus 4-bit slot index.
// - Slot-derived flag set when digest used a data slot.
// - Origin flag: 0 internal random, 1 host seed only.
// - Check-only flag set when digest used a verify-only key.
// - Valid cleared on power-up, sleep, brown-out, watchdog, tamper; idle keeps.
// - Valid cleared after any command but nonce, digest or successful MAC verify.
// - CRC-rejected command leaves valid unchanged.
// - MAC verify keeps valid only on a successful copy.
// - Error in nonce or digest clears valid.
// - Each nonce or digest result overwrites the key.
// - Generator makes a 32-bit word; nonce mixes eight copies with host input.
// - Random command returns generator output; key value kept, valid cleared.
// - Config unlocked: generator gives ff ff 00 00 repeating.
// - Encrypted access needs key from internal random nonce.
// - Lock bytes at config 87 and 86, changed only by lock command.
// - Locking holds until reset, which sets both lock bytes back to 55h.
`timescale 1ns/10ps
`include "zone_lock_regs.svh"

module zone_lock_and_ephemeral_key
    import zone_lock_pkg::*;
#(
    parameter int CFG_BYTES = `CFG_BYTES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Key to internal command logic
    output logic [255:0] keyValue,
    output logic keyValid
);

    typedef struct packed {
        logic [CFG_BYTES-1:0][7:0] cfg;
        eph_key_t key;
        logic [31:0] lfsr;
        logic [31:0] seedIn;
        logic [255:0] hashIn;
        logic [7:0] randByte;
        logic seedFresh;
        logic [2:0] verdict;
        logic [7:0] errCode;
        logic [31:0] randOut;
        apb_rsp_t rsp;
        logic [255:0] keyOut;
        logic keyValidOut;
    } state_t;

    state_t s;
    state_t next_s;

    logic cfgUnlocked;
    logic dataUnlocked;
    logic apbAccess;
    logic apbWrite;
    logic apbRead;
    logic [31:0] rdata;
    logic [31:0] genWord;

    assign cfgUnlocked = s.cfg[`CFG_LOCK_BYTE_ADDR] == `UNLOCKED_VALUE;
    assign dataUnlocked = s.cfg[`DATA_LOCK_BYTE_ADDR] == `UNLOCKED_VALUE;
    assign apbAccess = psel && penable && !s.rsp.pready;
    assign apbWrite = apbAccess && pwrite;
    assign apbRead = apbAccess && !pwrite;

    // Test pattern before config lock, else LFSR mixed with seed
    assign genWord = cfgUnlocked ? `PATTERN_WORD : (s.lfsr ^ s.seedIn);

    // Key value is deliberately absent from every readable word
    always_comb begin
        rdata = 32'h00000000;
        case (paddr)
            `REG_STATUS: rdata = {24'h000000, 3'b000, s.seedFresh,
                !dataUnlocked, !cfgUnlocked, s.key.valid, 1'b0};
            `REG_VERDICT: rdata = {21'h000000, s.errCode, s.verdict};
            `REG_RAND_OUT: rdata = s.randOut;
            `REG_KEY_META: rdata = {25'h0000000, s.key.verify_only_slot_bit,
                s.key.slotDerived, s.key.randomnessOrigin,
                s.key.slotIndex};
            `REG_CFG_RD: rdata = {24'h000000,
                s.cfg[pwdata[6:0] < 7'(CFG_BYTES) ? pwdata[6:0] : 7'd0]};
            default: rdata = 32'h00000000;
        endcase
    end

    always_comb begin
        logic [3:0] opSlot;
        logic opErr;
        logic opCrcErr;
        logic opSkipSeed;
        logic opMacOk;
        logic opVerifyOnly;
        logic opUseSlot;
        logic opEncrypted;
        logic opSlotRd;
        logic opSlotWr;
        logic [6:0] cfgAddr;
        cmd_t opCode;
        zone_t opZone;
        next_s = s;
        opSlot = pwdata[7:4];
        opErr = pwdata[8];
        opCrcErr = pwdata[9];
        opSkipSeed = pwdata[10];
        opMacOk = pwdata[11];
        opVerifyOnly = pwdata[12];
        opUseSlot = pwdata[13];
        opEncrypted = pwdata[14];
        opSlotRd = pwdata[15];
        opSlotWr = pwdata[16];
        cfgAddr = pwdata[14:8];
        opCode = cmd_t'(pwdata[3:0]);
        opZone = zone_t'(pwdata[18:17]);
        next_s.rsp.pready = apbAccess;
        next_s.rsp.pslverr = 1'b0;
        next_s.rsp.prdata = apbRead ? rdata : 32'h00000000;
        next_s.lfsr = {s.lfsr[30:0],
            s.lfsr[31] ^ s.lfsr[21] ^ s.lfsr[1] ^ s.lfsr[0]};
        // Lock bytes only move via lock command; back to 55h only on reset
        if (apbWrite && paddr == `REG_CFG_WR) begin
            if (cfgAddr <= `CFG_FIXED_LAST || !cfgUnlocked
                    || cfgAddr >= 7'(CFG_BYTES)
                    || cfgAddr == `CFG_LOCK_BYTE_ADDR
                    || cfgAddr == `DATA_LOCK_BYTE_ADDR) begin
                next_s.rsp.pslverr = 1'b1;
            end else begin
                next_s.cfg[cfgAddr] = pwdata[7:0];
            end
        end
        if (apbWrite && paddr == `REG_SEED_IN) begin
            next_s.seedIn = pwdata;
        end
        if (apbWrite && paddr == `REG_HASH_IN) begin
            next_s.hashIn = {s.hashIn[223:0], pwdata};
        end
        if (apbWrite && paddr == `REG_ACCESS) begin
            if (!cfgUnlocked && (opZone != ZONE_CONFIG)) begin
                if (dataUnlocked) begin
                    next_s.verdict = {1'b0, 1'b1, 1'b0};
                end else begin
                    next_s.verdict = {1'b0, opSlotWr, opSlotRd};
                end
            end else if (opZone != ZONE_CONFIG) begin
                next_s.verdict = 3'b100;
            end else begin
                next_s.verdict = {1'b0, cfgUnlocked, 1'b1};
            end
            if (opEncrypted && (!s.key.valid || s.key.randomnessOrigin)) begin
                next_s.verdict = 3'b100;
            end
        end
        if (apbWrite && paddr == `REG_CMD && !opCrcErr) begin
            next_s.errCode = 8'h00;
            next_s.key.valid = 1'b0;
            case (opCode)
                CMD_NONCE: begin
                    if (opErr) begin
                        next_s.errCode = `ERR_BAD_CMD;
                    end else begin
                        next_s.key.value = s.hashIn ^ {8{genWord}};
                        next_s.key.randomnessOrigin = opSkipSeed;
                        next_s.key.slotDerived = 1'b0;
                        next_s.key.verify_only_slot_bit = 1'b0;
                        next_s.key.valid = 1'b1;
                    end
                    if (s.seedFresh && !opSkipSeed) begin
                        next_s.seedFresh = 1'b0;
                        next_s.seedIn = s.seedIn ^ s.lfsr;
                    end
                end
                CMD_DIGEST: begin
                    if (opErr) begin
                        next_s.errCode = `ERR_BAD_CMD;
                    end else begin
                        next_s.key.value = {s.key.value[254:0],
                            s.key.value[255]} ^ s.hashIn;
                        next_s.key.slotIndex = opSlot;
                        next_s.key.slotDerived = opUseSlot;
                        next_s.key.verify_only_slot_bit = opVerifyOnly;
                        next_s.key.valid = s.key.valid;
                    end
                end
                CMD_RANDOM: begin
                    next_s.randOut = genWord;
                    if (s.seedFresh && !opSkipSeed) begin
                        next_s.seedFresh = 1'b0;
                        next_s.seedIn = s.seedIn ^ s.lfsr;
                    end
                end
                CMD_MAC_VERIFY: begin
                    next_s.key.valid = s.key.valid && opMacOk;
                end
                CMD_LOCK: begin
                    // Only write non-55h values; only reset restores 55h
                    if (opSlot[0]) begin
                        next_s.cfg[`CFG_LOCK_BYTE_ADDR] = 8'h00;
                    end else if (!cfgUnlocked) begin
                        next_s.cfg[`DATA_LOCK_BYTE_ADDR] = 8'h00;
                    end
                end
                default: next_s.errCode = 8'h00;
            endcase
        end
        if (apbWrite && paddr == `REG_CTRL) begin
            if (pwdata[`CTRL_SLEEP]) begin
                next_s.key = '0;
                next_s.hashIn = '0;
                next_s.randOut = '0;
                next_s.seedFresh = 1'b1;
            end else if (pwdata[`CTRL_BROWNOUT] || pwdata[`CTRL_WATCHDOG]
                    || pwdata[`CTRL_TAMPER]) begin
                next_s.key.valid = 1'b0;
            end
        end
        next_s.keyOut = next_s.key.value;
        next_s.keyValidOut = next_s.key.valid;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            for (int i = 0; i < CFG_BYTES; i++) begin
                s.cfg[i] <= `UNLOCKED_VALUE;
            end
            s.lfsr <= `SEED_INIT;
            s.seedFresh <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rsp.prdata;
    assign pready = s.rsp.pready;
    assign pslverr = s.rsp.pslverr;
    assign keyValue = s.keyOut;
    assign keyValid = s.keyValidOut;

endmodule : zone_lock_and_ephemeral_key

// *** zone_lock_regs.svh ***
// Constants for the zone lock and ephemeral key block.
// Assumes a register map reached over a 32-bit APB slave.
`ifndef ZONE_LOCK_REGS_SVH
`define ZONE_LOCK_REGS_SVH

`define UNLOCKED_VALUE 8'h55
`define CFG_LOCK_BYTE_ADDR 7'd87
`define DATA_LOCK_BYTE_ADDR 7'd86
`define CFG_FIXED_LAST 7'd12
`define CFG_BYTES 88

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_CMD 12'h008
`define REG_ACCESS 12'h00C
`define REG_VERDICT 12'h010
`define REG_CFG_WR 12'h014
`define REG_CFG_RD 12'h018
`define REG_SEED_IN 12'h01C
`define REG_RAND_OUT 12'h020
`define REG_KEY_META 12'h024
`define REG_HASH_IN 12'h028

`define CTRL_SLEEP 0
`define CTRL_BROWNOUT 1
`define CTRL_WATCHDOG 2
`define CTRL_TAMPER 3
`define CTRL_IDLE 4

`define PATTERN_WORD 32'h0000FFFF
`define SEED_INIT 32'h1
`define ERR_BAD_CMD 8'h03

`endif

// *** zone_lock_pkg.sv ***
// Types shared by the zone lock and ephemeral key block.
// Assumes the companion constant header for numeric values.
package zone_lock_pkg;

    typedef enum logic [3:0] {
        CMD_NONCE = 4'b0001,
        CMD_DIGEST = 4'b0010,
        CMD_RANDOM = 4'b0011,
        CMD_MAC_VERIFY = 4'b0100,
        CMD_READ = 4'b0101,
        CMD_WRITE = 4'b0110,
        CMD_LOCK = 4'b0111,
        CMD_OTHER = 4'b1000
    } cmd_t;

    typedef enum logic [1:0] {
        ZONE_CONFIG = 2'b00,
        ZONE_OTP = 2'b01,
        ZONE_DATA = 2'b10
    } zone_t;

    typedef struct packed {
        logic [255:0] value;
        logic [3:0] slotIndex;
        logic randomnessOrigin;
        logic slotDerived;
        logic verify_only_slot_bit;
        logic valid;
    } eph_key_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

endpackage : zone_lock_pkg

// *** zone_lock_checker.sv ***
// Port checker for the zone lock and ephemeral key block.
// Assumes binding onto the top module, one clock, active-high reset.
`timescale 1ns/10ps
`include "zone_lock_regs.svh"
module zone_lock_checker #(
    parameter int CFG_BYTES = `CFG_BYTES
) (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Key side
    input wire logic [255:0] keyValue,
    input wire logic keyValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic take = psel && penable && !pready && pwrite;
    wire logic ctl = take && paddr == `REG_CTRL;
    wire logic cmd = take && paddr == `REG_CMD && !pwdata[9];
    wire logic [3:0] op = pwdata[3:0];
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("ready late");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    property p_fixed;
        take && paddr == `REG_CFG_WR && (pwdata[14:8] <= `CFG_FIXED_LAST
            || pwdata[14:8] >= CFG_BYTES) |=> pready && pslverr;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed byte written");
    property p_wipe;
        ctl && pwdata[0] |-> ##[1:3] (!keyValid && keyValue == '0);
    endproperty
    a_wipe: assert property (p_wipe) else $error("sleep kept key");
    property p_clear;
        ctl && pwdata[3:0] != 4'h0 |-> ##[1:3] !keyValid;
    endproperty
    a_clear: assert property (p_clear) else $error("event kept valid");
    property p_other;
        cmd && !(op inside {4'h1, 4'h2}) && !(op == 4'h4 && pwdata[11])
            |-> ##[1:3] !keyValid;
    endproperty
    a_other: assert property (p_other) else $error("cmd kept valid");
    property p_crc;
        take && paddr == `REG_CMD && pwdata[9] |=> $stable(keyValid) [*3];
    endproperty
    a_crc: assert property (p_crc) else $error("crc changed valid");
    property p_gen_err;
        cmd && op inside {4'h1, 4'h2} && pwdata[8] |-> ##[1:3] !keyValid;
    endproperty
    a_gen_err: assert property (p_gen_err) else $error("error kept");
    c_sleep: cover property (ctl && pwdata[0]);
    c_refused: cover property (pslverr);
    c_valid: cover property ($rose(keyValid));
endmodule : zone_lock_checker

bind zone_lock_and_ephemeral_key zone_lock_checker #(
    .CFG_BYTES(CFG_BYTES)
) i_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .keyValue, .keyValid);

// *** apb_host.sv ***
// Host model issuing register requests over APB.
// Assumes one ref_clk domain; signals change just after rising edges.
`timescale 1ns/10ps
module apb_host (
    // Clock and answer
    input wire logic ref_clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    logic hung = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hung = pready !== 1'b1;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data goes stale on purpose, never the old word
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host

// *** tb.sv ***
// Self-checking bench for the zone lock and ephemeral key block.
// Assumes the host model for bus traffic and the bound checker.
`timescale 1ns/10ps
`include "zone_lock_regs.svh"
module tb;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, keyValid;
    logic err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [255:0] keyValue, nk;
    int fails = 0;
    int checked = 0;
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    zone_lock_and_ephemeral_key i_dut (.ref_clk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keyValue,
        .keyValid);
    apb_host i_host (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    task stop_test;
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [256:0] got, input logic [256:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Registered outputs need one more edge to land
    task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(w, a, d, rdv, err);
        if (i_host.hung) begin
            fails++;
            stop_test();
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : xf
    task acc(input logic [31:0] d, input logic [1:0] exp);
        xf(1'b1, `REG_ACCESS, d);
        xf(1'b0, `REG_VERDICT, 32'h0);
        chk(rdv[1:0], exp);
    endtask : acc
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        xf(1'b0, `REG_STATUS, 32'h0);
        chk(rdv[4:1], 4'b1000);
        xf(1'b1, `REG_CMD, 32'h3);
        xf(1'b0, `REG_RAND_OUT, 32'h0);
        chk(rdv, `PATTERN_WORD);
        xf(1'b1, `REG_HASH_IN, 32'h1234_5678);
        xf(1'b1, `REG_CMD, 32'h1);
        nk = {8{`PATTERN_WORD}} ^ 256'h1234_5678;
        chk({keyValid, keyValue}, {1'b1, nk});
        xf(1'b1, `REG_CMD, 32'h3);
        chk({keyValid, keyValue}, {1'b0, nk});
        xf(1'b1, `REG_CMD, 32'h1);
        xf(1'b1, `REG_CMD, 32'h3052);
        xf(1'b0, `REG_KEY_META, 32'h0);
        chk(rdv[6:0], 7'h65);
        xf(1'b1, `REG_CMD, 32'h208);
        chk(keyValid, 1'b1);
        xf(1'b1, `REG_CMD, 32'h804);
        chk(keyValid, 1'b1);
        xf(1'b1, `REG_CMD, 32'h101);
        xf(1'b0, `REG_VERDICT, 32'h0);
        chk({keyValid, rdv[10:2]}, 10'h006);
        xf(1'b1, `REG_CMD, 32'h1);
        xf(1'b1, `REG_CTRL, 32'h10);
        chk(keyValid, 1'b1);
        xf(1'b1, `REG_CTRL, 32'h1);
        chk({keyValid, keyValue}, 257'h0);
        xf(1'b1, `REG_CTRL, 32'h0);
        acc(32'h5_8000, 2'b00);
        xf(1'b1, `REG_CFG_WR, 32'h05AB);
        chk(err, 1'b1);
        xf(1'b1, `REG_CFG_WR, 32'h57AB);
        chk(err, 1'b1);
        xf(1'b1, `REG_CFG_WR, 32'h14AB);
        xf(1'b0, `REG_CFG_RD, 32'h14);
        chk({err, rdv[7:0]}, 9'h0AB);
        xf(1'b1, `REG_CMD, 32'h17);
        xf(1'b1, `REG_CFG_WR, 32'h14CD);
        chk(err, 1'b1);
        acc(32'h5_8000, 2'b10);
        xf(1'b1, `REG_CMD, 32'h7);
        xf(1'b1, `REG_CMD, 32'h17);
        xf(1'b0, `REG_STATUS, 32'h0);
        chk(rdv[3:2], 2'b11);
        acc(32'h4_8000, 2'b01);
        xf(1'b1, `REG_CMD, 32'h401);
        acc(32'h5_C000, 2'b00);
        xf(1'b1, `REG_CMD, 32'h1);
        acc(32'h5_C000, 2'b11);
        stop_test();
    end
endmodule : tb
